// [verilog/wrp_cfg.svh]
// register offsets, field positions and reset values of the working-register pointer
`ifndef WRP_CFG_SVH
`define WRP_CFG_SVH
// register indices, and byte addresses on the register bus at four times the index
`define WRP_UPPER_IDX 8'he9
`define WRP_LOWER_IDX 8'he8
`define WRP_STATUS_IDX 8'hea
`define WRP_UPPER_ADDR 12'h3a4
`define WRP_LOWER_ADDR 12'h3a0
`define WRP_STATUS_ADDR 12'h3a8
// field layout of a pointer byte
`define WRP_BLK_HI 7
`define WRP_BLK_LO 3
`define WRP_MODE_BIT 2
// pointer reset value; block bits have no defined reset, zero chosen
`define WRP_PTR_RESET 8'h00
// answers on the register bus
`define WRP_RESP_OKAY 2'b00
`define WRP_RESP_SLVERR 2'b10
`endif

// [verilog/wrp_pkg.sv]
// types shared by the working-register pointer
package wrp_pkg;
    // pointer instruction issued by the core
    typedef enum logic [1:0] {
        WRP_OP_NONE,
        WRP_OP_SINGLE,
        WRP_OP_LOW,
        WRP_OP_HIGH
    } wrp_op_t;
    // bus slave phase
    typedef enum logic [1:0] {
        WRP_IDLE,
        WRP_WRESP,
        WRP_RRESP
    } wrp_phase_t;
endpackage

// [verilog/wrp_pointer.sv]
// working-register pointer pair with address mapping and register bus slave
// Contract
// RQ1: pointer upper five bits hold block 0..31
// RQ2: single mode maps sixteen onto two blocks
// RQ3: twin mode maps r0-r7 via first pointer
// RQ4: twin mode maps r8-r15 via second pointer
// RQ5: half instructions set mode, single clears
// RQ6: two lowest pointer bits always zero
// RQ7: software keeps second pointer reserved outside twin
// RQ8: address is block times eight plus index
`timescale 1ns/1ps
`include "wrp_cfg.svh"
module wrp_pointer #(
    parameter int BLOCK_BITS = 5,
    parameter int ADDR_W = 12
) (
    clk,
    reset,
    instrOp,
    instrBlock,
    workReg,
    fileAddr,
    twinMode,
    awvalid,
    awready,
    awaddr,
    wvalid,
    wready,
    wdata,
    wstrb,
    bvalid,
    bready,
    bresp,
    arvalid,
    arready,
    araddr,
    rvalid,
    rready,
    rdata,
    rresp
);
    input wire logic clk; // core clock
    input wire logic reset; // synchronous, active high
    input wire wrp_pkg::wrp_op_t instrOp; // one-cycle pointer instruction
    input wire logic [BLOCK_BITS-1:0] instrBlock; // block operand
    input wire logic [3:0] workReg; // working register r0..r15
    output logic [BLOCK_BITS+2:0] fileAddr; // register-file address
    output logic twinMode; // pointer mode bit
    input wire logic awvalid;
    output logic awready;
    input wire logic [ADDR_W-1:0] awaddr;
    input wire logic wvalid;
    output logic wready;
    input wire logic [31:0] wdata;
    input wire logic [3:0] wstrb;
    output logic bvalid;
    input wire logic bready;
    output logic [1:0] bresp;
    input wire logic arvalid;
    output logic arready;
    input wire logic [ADDR_W-1:0] araddr;
    output logic rvalid;
    input wire logic rready;
    output logic [31:0] rdata;
    output logic [1:0] rresp;

    // field width fixed by the pointer byte layout; refused while elaborating
    // the address must reach the three register words of the window
    if (BLOCK_BITS != `WRP_BLK_HI - `WRP_BLK_LO + 1 || ADDR_W < 12)
    begin : g_bad_params
        $error("wrp_pointer: unsupported parameters");
    end

    // whole state in one record
    typedef struct packed {
        logic [BLOCK_BITS-1:0] lowBlk; // first pointer block
        logic [BLOCK_BITS-1:0] highBlk; // second pointer block
        logic mode; // 1 twin, 0 single
        logic awTaken; // write address held
        logic wTaken; // write data held
        logic [ADDR_W-1:0] wAddr;
        logic [31:0] wData;
        logic wLane0; // byte lane 0 strobe
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } wrp_state_t;

    wrp_state_t state_reg;
    wrp_state_t state_next;

    // pointer byte view; lowest two bits forced to zero
    function automatic logic [7:0] ptrByte(input logic [BLOCK_BITS-1:0] blk, input logic m);
        logic [7:0] b;
        b = `WRP_PTR_RESET;
        // RQ6 low bits zero
        b[`WRP_BLK_HI:`WRP_BLK_LO] = blk;
        b[`WRP_MODE_BIT] = m;
        ptrByte = b;
    endfunction

    // which register an address selects: 0 none, 1 lower, 2 upper, 3 status
    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        decode = 2'd0;
        if (a == ADDR_W'(`WRP_LOWER_ADDR))
            decode = 2'd1;
        else if (a == ADDR_W'(`WRP_UPPER_ADDR))
            decode = 2'd2;
        else if (a == ADDR_W'(`WRP_STATUS_ADDR))
            decode = 2'd3;
    endfunction

    // next-state logic: instructions, bus writes and reads
    always_comb
    begin
        logic doWrite;
        logic [1:0] sel;
        state_next = state_reg;
        doWrite = 1'b0;
        sel = 2'd0;
        // channel capture, either order
        if (awvalid && !state_reg.awTaken && !state_reg.bValid)
        begin
            state_next.awTaken = 1'b1;
            state_next.wAddr = awaddr;
        end
        if (wvalid && !state_reg.wTaken && !state_reg.bValid)
        begin
            state_next.wTaken = 1'b1;
            state_next.wData = wdata;
            state_next.wLane0 = wstrb[0];
        end
        if (state_reg.bValid && bready)
            state_next.bValid = 1'b0;
        // both halves present: perform write, answer next cycle
        if (state_reg.awTaken && state_reg.wTaken && !state_reg.bValid)
        begin
            doWrite = state_reg.wLane0;
            sel = decode(state_reg.wAddr);
            state_next.awTaken = 1'b0;
            state_next.wTaken = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = (sel == 2'd0) ? `WRP_RESP_SLVERR : `WRP_RESP_OKAY;
        end
        // software write: block field only; mode bit follows instructions
        if (doWrite && sel == 2'd1)
            state_next.lowBlk = state_reg.wData[`WRP_BLK_HI:`WRP_BLK_LO];
        if (doWrite && sel == 2'd2)
            state_next.highBlk = state_reg.wData[`WRP_BLK_HI:`WRP_BLK_LO];
        // instruction wins over a software write in the same cycle
        case (instrOp)
            wrp_pkg::WRP_OP_SINGLE:
            begin
                // RQ1 load block
                state_next.lowBlk = instrBlock;
                // RQ5 clear mode
                state_next.mode = 1'b0;
            end
            wrp_pkg::WRP_OP_LOW:
            begin
                state_next.lowBlk = instrBlock;
                // RQ5 set mode
                state_next.mode = 1'b1;
            end
            wrp_pkg::WRP_OP_HIGH:
            begin
                // RQ4 second block
                state_next.highBlk = instrBlock;
                state_next.mode = 1'b1;
            end
            default:
            begin
                state_next.mode = state_reg.mode;
            end
        endcase
        // read channel, one cycle latency
        if (state_reg.rValid && rready)
            state_next.rValid = 1'b0;
        if (arvalid && !state_reg.rValid)
        begin
            state_next.rValid = 1'b1;
            state_next.rResp = `WRP_RESP_OKAY;
            case (decode(araddr))
                2'd1: state_next.rData = {24'h000000, ptrByte(state_reg.lowBlk, state_reg.mode)};
                2'd2: state_next.rData = {24'h000000, ptrByte(state_reg.highBlk, state_reg.mode)};
                2'd3: state_next.rData = {31'h00000000, state_reg.mode};
                default:
                begin
                    state_next.rData = 32'h00000000;
                    state_next.rResp = `WRP_RESP_SLVERR;
                end
            endcase
        end
        if (reset)
        begin
            state_next = '0;
        end
    end

    // single register stage
    always_ff @(posedge clk)
    begin
        state_reg <= state_next;
    end

    // address mapping, combinational from the pointers
    always_comb
    begin
        logic [BLOCK_BITS-1:0] blk;
        blk = state_reg.lowBlk;
        if (!state_reg.mode)
        begin
            // RQ2 consecutive pair; wraps past block 31
            blk = state_reg.lowBlk + BLOCK_BITS'(workReg[3]);
        end
        else if (workReg[3])
        begin
            // RQ4 upper eight
            blk = state_reg.highBlk;
        end
        else
        begin
            // RQ3 lower eight
            blk = state_reg.lowBlk;
        end
        // RQ8 block times eight plus index
        fileAddr = {blk, workReg[2:0]};
    end

    assign twinMode = state_reg.mode;
    // handshake outputs
    assign awready = !state_reg.awTaken && !state_reg.bValid;
    assign wready = !state_reg.wTaken && !state_reg.bValid;
    assign bvalid = state_reg.bValid;
    assign bresp = state_reg.bResp;
    assign arready = !state_reg.rValid;
    assign rvalid = state_reg.rValid;
    assign rdata = state_reg.rData;
    assign rresp = state_reg.rResp;

    // named steps of the instruction port
    sequence s_half_instr;
        instrOp == wrp_pkg::WRP_OP_LOW || instrOp == wrp_pkg::WRP_OP_HIGH;
    endsequence
    sequence s_no_instr;
        instrOp == wrp_pkg::WRP_OP_NONE;
    endsequence
    // high-half load, then an upper register used in the next cycle
    sequence s_high_then_upper;
        instrOp == wrp_pkg::WRP_OP_HIGH ##1 workReg[3];
    endsequence

    // RQ5 half instruction sets mode
    chk_mode_set: assert property (@(posedge clk) disable iff (reset) // RQ5
        s_half_instr |=> twinMode)
        else $error("mode not set by half instruction");

    // RQ5 single instruction clears mode
    chk_mode_clear: assert property (@(posedge clk) disable iff (reset) // RQ5
        instrOp == wrp_pkg::WRP_OP_SINGLE |=> !twinMode)
        else $error("mode not cleared by single instruction");

    // RQ5 mode held between instructions
    // bus writes must never touch the mode bit
    chk_mode_hold: assert property (@(posedge clk) disable iff (reset) // RQ5
        s_no_instr |=> $stable(twinMode))
        else $error("mode changed without an instruction");

    // RQ1 low-half instruction loads block
    chk_block_load: assert property (@(posedge clk) disable iff (reset) // RQ1
        instrOp == wrp_pkg::WRP_OP_LOW |=> state_reg.lowBlk == $past(instrBlock))
        else $error("first pointer not loaded");

    // RQ1 single instruction loads block
    chk_single_load: assert property (@(posedge clk) disable iff (reset) // RQ1
        instrOp == wrp_pkg::WRP_OP_SINGLE |=> state_reg.lowBlk == $past(instrBlock))
        else $error("first pointer not loaded by single instruction");

    // RQ4 high-half instruction loads block
    chk_high_load: assert property (@(posedge clk) disable iff (reset) // RQ4
        instrOp == wrp_pkg::WRP_OP_HIGH |=> state_reg.highBlk == $past(instrBlock))
        else $error("second pointer not loaded");

    // RQ4 upper eight follow new block
    chk_high_map: assert property (@(posedge clk) disable iff (reset) // RQ4
        s_high_then_upper |-> fileAddr[BLOCK_BITS+2:3] == $past(instrBlock))
        else $error("upper eight not on the loaded block");

    // RQ2 single mode consecutive pair
    // modulo the file size: block 31 upper half wraps to block 0
    chk_single_map: assert property (@(posedge clk) disable iff (reset) // RQ2
        !twinMode |-> fileAddr == ((state_reg.lowBlk * 8 + workReg) % 256))
        else $error("single mode mapping wrong");

    // RQ3 twin lower eight mapping
    chk_twin_low: assert property (@(posedge clk) disable iff (reset) // RQ3
        twinMode && !workReg[3] |-> fileAddr[BLOCK_BITS+2:3] == state_reg.lowBlk)
        else $error("twin low mapping wrong");

    // RQ4 twin upper eight mapping
    chk_twin_high: assert property (@(posedge clk) disable iff (reset) // RQ4
        twinMode && workReg[3] |-> fileAddr[BLOCK_BITS+2:3] == state_reg.highBlk)
        else $error("twin high mapping wrong");

    // RQ8 index within block kept
    chk_index_keep: assert property (@(posedge clk) disable iff (reset) // RQ8
        fileAddr[2:0] == workReg[2:0])
        else $error("index within block lost");

    // RQ6 pointer reads carry zero
    // status word is left out: its bit 0 is the mode
    chk_low_bits: assert property (@(posedge clk) disable iff (reset) // RQ6
        arvalid && arready && (decode(araddr) == 2'd1 || decode(araddr) == 2'd2)
        |=> rdata[1:0] == 2'b00)
        else $error("reserved pointer bits not zero");
endmodule

// [sim/wrp_core_model.sv]
// core-side model that issues pointer instructions
`timescale 1ns/1ps
module wrp_core_model (
    clk,
    instrOp,
    instrBlock
);
    input wire logic clk; // core clock
    output wrp_pkg::wrp_op_t instrOp; // one-cycle instruction
    output logic [4:0] instrBlock; // block operand
    // idle until the first instruction
    initial
    begin
        instrOp = wrp_pkg::WRP_OP_NONE;
        instrBlock = 5'h00;
    end
    // second pointer never used as storage
    // operand is scrambled once the pulse ends, so stale values never pass
    task automatic issue(input wrp_pkg::wrp_op_t op, input logic [4:0] b);
        instrOp <= op;
        instrBlock <= b;
        @(posedge clk);
        instrOp <= wrp_pkg::WRP_OP_NONE;
        instrBlock <= ~b;
    endtask
    // two instructions in consecutive cycles, no idle cycle between them
    task automatic pair(input wrp_pkg::wrp_op_t op0, input logic [4:0] b0,
        input wrp_pkg::wrp_op_t op1, input logic [4:0] b1);
        instrOp <= op0;
        instrBlock <= b0;
        @(posedge clk);
        instrOp <= op1;
        instrBlock <= b1;
        @(posedge clk);
        instrOp <= wrp_pkg::WRP_OP_NONE;
        instrBlock <= ~b1;
    endtask
endmodule

// [sim/tb_working_register_pointer.sv]
// self-checking bench for the working-register pointer
`timescale 1ns/1ps
`include "wrp_cfg.svh"
module tb_working_register_pointer;
    logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, twinMode;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, workReg;
    logic [1:0] bresp, rresp;
    logic [7:0] fileAddr;
    logic [4:0] instrBlock, a, c;
    wrp_pkg::wrp_op_t instrOp;
    logic [33:0] expQ[$]; // pending bus answers
    int error_cnt, comparisons, i;
    wrp_core_model i_core (.clk(clk), .instrOp(instrOp), .instrBlock(instrBlock));
    wrp_pointer i_dut (.clk(clk), .reset(reset), .instrOp(instrOp), .instrBlock(instrBlock),
        .workReg(workReg), .fileAddr(fileAddr), .twinMode(twinMode), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));
    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // answers taken off the queue as they appear
    always @(posedge clk)
    begin
        if ((bvalid && bready) || (rvalid && rready))
        begin
            if (expQ.size() == 0)
            begin
                error_cnt++;
                $display("unexpected answer: expected none seen %h", {rresp, rdata});
            end
            else if (bvalid && bready)
                chk("bresp", expQ.pop_front(), {bresp, 32'h0});
            else
                chk("rdata", expQ.pop_front(), {rresp, rdata});
        end
    end
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        expQ.push_back({r, 32'h0});
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [33:0] e);
        @(posedge clk);
        expQ.push_back(e);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // mapping is combinational, so it is looked at one edge later
    task automatic map(input logic [3:0] w, input logic [7:0] e, input logic t);
        workReg <= w;
        @(posedge clk);
        chk("fileAddr", {26'h0, e}, {26'h0, fileAddr});
        chk("twinMode", {33'h0, t}, {33'h0, twinMode});
    endtask
    // watchdog, far beyond the roughly 160 cycles the tests need
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
    // main sequence
    initial
    begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, workReg} = 60'h0;
        wstrb = 4'hf;
        void'($urandom(32'h2a330c33));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(`WRP_LOWER_ADDR, 34'h0);
        rd(`WRP_STATUS_ADDR, 34'h0);
        rd(12'h3ac, {`WRP_RESP_SLVERR, 32'h0});
        wr(12'h3ac, 32'hff, `WRP_RESP_SLVERR);
        // top block in single mode: upper half wraps to block 0
        i_core.issue(wrp_pkg::WRP_OP_SINGLE, 5'h1f);
        map(4'hc, 8'h04, 1'b0);
        map(4'h7, 8'hff, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            a = 5'($urandom);
            c = 5'($urandom);
            i_core.issue(wrp_pkg::WRP_OP_SINGLE, a);
            map(4'h9, 8'(a * 8 + 9), 1'b0);
            // back-to-back half instructions
            i_core.pair(wrp_pkg::WRP_OP_LOW, a, wrp_pkg::WRP_OP_HIGH, c);
            map(4'hf, 8'(c * 8 + 7), 1'b1);
            map(4'h3, 8'(a * 8 + 3), 1'b1);
            rd(`WRP_UPPER_ADDR, {26'h0, c, 3'h4});
            rd(`WRP_LOWER_ADDR, {26'h0, a, 3'h4});
            rd(`WRP_STATUS_ADDR, 34'h1);
        end
        wr(`WRP_UPPER_ADDR, 32'hff, `WRP_RESP_OKAY);
        rd(`WRP_UPPER_ADDR, {26'h0, 8'hfc});
        // byte lane 0 not strobed: answered OKAY, pointer kept
        wstrb <= 4'he;
        wr(`WRP_LOWER_ADDR, 32'hff, `WRP_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`WRP_LOWER_ADDR, {26'h0, a, 3'h4});
        map(4'h8, 8'hf8, 1'b1);
        i_core.issue(wrp_pkg::WRP_OP_SINGLE, 5'h02);
        rd(`WRP_UPPER_ADDR, {26'h0, 8'hf8});
        i_core.issue(wrp_pkg::WRP_OP_HIGH, 5'h1f);
        map(4'h1, 8'h11, 1'b1);
        results();
    end
endmodule
